// ===== verilog/iqpv_top.v
/*
  interrupt priority fields for dma channels 6 and 7 plus the
  read-only cpu level and pending vector status, on an apb slave.
  assumes the arbiter supplies the level and vector synchronously.
*/
// Added by the designer: the APB interface to the registers and the register offsets.
// Behaviour
// - bits 6 to 4 of the priority register hold the channel 7 completion priority.
// - a code of 111 is level 7, the highest, down to 001 meaning level 1.
// - status bits 6 to 0 show the read-only pending vector number.
// - vector code 0111111 means vector 135 and the field resets to zero.
// - every priority field resets to level 4.
`timescale 1ns/1ps
`include "iqpv_defines.vh"

module iqpv_top (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output wire o_pready,
  output wire [31:0] o_prdata,
  output wire o_pslverr,
  // completion sources
  input wire i_chan6_done,
  input wire i_chan7_done,
  // arbiter status
  input wire [3:0] i_new_cpu_level,
  input wire [6:0] i_pending_vector_number,
  input wire i_status_load,
  // gated requests and their levels
  output wire o_chan6_req,
  output wire o_chan7_req,
  output wire [2:0] o_chan6_done_priority,
  output wire [2:0] o_chan7_done_priority
);

  wire acc;
  wire hit_prio;
  wire hit_stat;
  wire wr_prio;
  wire [15:0] prio_word;
  wire [15:0] stat_word;
  reg [31:0] rdata_q;
  reg [6:0] vec_q;
  reg [3:0] lvl_q;

  // bus decode, zero wait states
  assign acc = i_psel && i_penable;
  assign hit_prio = (i_paddr == `IQPV_OFF_PRIO);
  assign hit_stat = (i_paddr == `IQPV_OFF_STAT);
  assign wr_prio = acc && i_pwrite && hit_prio && i_pstrb[0];
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !(hit_prio || (hit_stat && !i_pwrite));

  // channel 7 field at bits 6..4
  iqpv_prio_field u_ch7 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr_prio),
    .i_wdata(i_pwdata[`IQPV_CH7_MSB:`IQPV_CH7_LSB]),
    .i_src_req(i_chan7_done),
    .o_prio(o_chan7_done_priority),
    .o_req(o_chan7_req)
  );

  // channel 6 field at bits 2..0
  iqpv_prio_field u_ch6 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr_prio),
    .i_wdata(i_pwdata[`IQPV_CH6_MSB:`IQPV_CH6_LSB]),
    .i_src_req(i_chan6_done),
    .o_prio(o_chan6_done_priority),
    .o_req(o_chan6_req)
  );

  // status capture from the arbiter, read only
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vec_q <= `IQPV_VEC_RST;
      lvl_q <= `IQPV_LVL_RST;
    end
    else if (i_status_load)
    begin
      vec_q <= i_pending_vector_number;
      lvl_q <= i_new_cpu_level;
    end
  end

  // unimplemented bits read zero
  assign prio_word = {9'h000, o_chan7_done_priority, 1'b0, o_chan6_done_priority};
  assign stat_word = {4'h0, lvl_q, 1'b0, vec_q};

  // read data registered in the setup cycle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      if (i_paddr == `IQPV_OFF_PRIO)
        rdata_q <= {16'h0000, prio_word};
      else if (i_paddr == `IQPV_OFF_STAT)
        rdata_q <= {16'h0000, stat_word};
      else
        rdata_q <= 32'h00000000;
    end
  end

  assign o_prdata = rdata_q;

endmodule // iqpv_top

// ===== verilog/iqpv_defines.vh
/*
  register offsets, field positions, reset values and codes for the
  interrupt priority and pending vector block.
  assumes a 32-bit apb slave with one aligned word per register.
*/
`ifndef IQPV_DEFINES_VH
`define IQPV_DEFINES_VH

// register byte offsets
`define IQPV_OFF_PRIO 12'h000
`define IQPV_OFF_STAT 12'h004
`define IQPV_ADDR_W 12

// priority register fields
`define IQPV_CH7_LSB 4
`define IQPV_CH7_MSB 6
`define IQPV_CH6_LSB 0
`define IQPV_CH6_MSB 2
`define IQPV_PRIO_RST 3'h4
`define IQPV_PRIO_OFF 3'h0
`define IQPV_PRIO_TOP 3'h7

// status register fields
`define IQPV_VEC_LSB 0
`define IQPV_VEC_MSB 6
`define IQPV_LVL_LSB 8
`define IQPV_LVL_MSB 11
`define IQPV_VEC_TOP 7'h3f
`define IQPV_VEC_RST 7'h00
`define IQPV_LVL_RST 4'h0

`endif

// ===== verilog/iqpv_prio_field.v
/*
  one 3-bit priority field with reset to level 4 and a request gate.
  assumes writes come as a one-cycle strobe from the bus slave.
*/
`timescale 1ns/1ps
`include "iqpv_defines.vh"

module iqpv_prio_field (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // write side
  input wire i_wr,
  input wire [2:0] i_wdata,
  // source side
  input wire i_src_req,
  output wire [2:0] o_prio,
  output wire o_req
);

  reg [2:0] prio_q;

  // field storage, level 4 out of reset
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prio_q <= `IQPV_PRIO_RST;
    else if (i_wr)
      prio_q <= i_wdata;
  end

  // code 000 mutes the source
  assign o_req = i_src_req && (prio_q != `IQPV_PRIO_OFF);
  assign o_prio = prio_q;

endmodule // iqpv_prio_field

// ===== tb/iqpv_assertions.sv
/* port checks for iqpv_top
   bound to every instance, sees top ports only */
`timescale 1ns/1ps
module iqpv_checker (
  // clock, reset and bus
  input wire i_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  // channel 7 source
  input wire i_chan7_done,
  input wire o_chan7_req,
  input wire [2:0] o_chan7_done_priority
);
  // taken priority write
  wire wr0 = i_psel && i_penable && i_pwrite && i_paddr == 12'h000 && i_pstrb[0];
  wire rd4 = i_psel && i_penable && !i_pwrite && i_paddr == 12'h004;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_CH7_FIELD: assert property (wr0 |=> o_chan7_done_priority == $past(i_pwdata[6:4]))
    else $error("ch7 field not written");
  AST_HOLD: assert property (!wr0 |=> $stable(o_chan7_done_priority))
    else $error("priority changed without write");
  AST_STAT_ZERO: assert property (rd4 |-> o_prdata[31:12] == 20'h0 && !o_prdata[7])
    else $error("status spare bits set");
  AST_STAT_RO: assert property (rd4 || (i_psel && i_penable && i_paddr == 12'h004) |-> o_pslverr == i_pwrite)
    else $error("status write not refused");
  AST_RST: assert property ($rose(i_rst_n) |-> o_chan7_done_priority == 3'h4)
    else $error("priority reset wrong");
  AST_GATE: assert property (o_chan7_req == (i_chan7_done && o_chan7_done_priority != 3'h0))
    else $error("request gate wrong");
endmodule // iqpv_checker
bind iqpv_top iqpv_checker i_iqpv_checker (.*);

// ===== tb/tb_top.sv
/* self-checking bench for iqpv_top
   drives apb and arbiter inputs directly */
`timescale 1ns/1ps
module tb_top;
  logic c = 0, rn = 0, ps = 0, pe = 0, pw = 0, d6 = 1, d7 = 1, ld = 0, rdy, er, q6, q7;
  logic [11:0] pa = 12'h0;
  logic [31:0] wd = 32'h0, rd, pr;
  logic [2:0] p6, p7;
  logic se; // error response taken at the access edge
  int n_mismatch = 0, checked = 0;
  iqpv_top i_iqpv_top (.i_clk(c), .i_rst_n(rn), .i_psel(ps), .i_penable(pe), .i_pwrite(pw),
    .i_paddr(pa), .i_pwdata(wd), .i_pstrb(4'hf), .o_pready(rdy), .o_prdata(pr), .o_pslverr(er),
    .i_chan6_done(d6), .i_chan7_done(d7), .i_new_cpu_level(4'h7), .i_pending_vector_number(7'h3f),
    .i_status_load(ld), .o_chan6_req(q6), .o_chan7_req(q7), .o_chan6_done_priority(p6),
    .o_chan7_done_priority(p7));
  initial forever #4 c = ~c;
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %0t exp %h got %h", $time, e, g);
    end
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    ps <= 1; pw <= w; pa <= a; wd <= d;
    @(posedge c);
    pe <= 1;
    n = 0;
    do begin @(posedge c); n++; end while (rdy !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      finish_test;
    end
    rd = pr;
    se = er;
    ps <= 0; pe <= 0;
    @(posedge c);
  endtask
  initial
  begin
    repeat (10) @(posedge c);
    rn <= 1;
    @(posedge c);
    apb(0, 12'h000, 0); cmp(32'h44, rd);
    cmp(32'h0, {31'h0, se});
    apb(0, 12'h008, 0); cmp(32'h1, {31'h0, se});
    cmp(32'h0, rd);
    apb(0, 12'h004, 0); cmp(32'h0, rd);
    apb(1, 12'h000, 32'hffffffff); cmp(32'h7, {29'h0, p7});
    apb(0, 12'h000, 0); cmp(32'h77, rd);
    apb(1, 12'h000, 32'h5); cmp(32'h0, {31'h0, q7});
    cmp(32'h1, {31'h0, q6});
    apb(1, 12'h000, 32'h30); cmp(32'h3, {29'h0, p7});
    ld <= 1;
    @(posedge c);
    ld <= 0;
    apb(1, 12'h004, 0); cmp(32'h1, {31'h0, se});
    apb(0, 12'h004, 0); cmp(32'h73f, rd);
    cmp(32'h0, {31'h0, se});
    finish_test;
  end
endmodule // tb_top
